// ### core/cmc_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmc_cfg.svh"
module cmc_mode_ctrl
  import cmc_pkg::*;
#(
  parameter int DEPTH = `CMC_BUF_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         module_enable_bit,
  input  wire logic         init_request,
  input  wire logic         sleep_request,
  input  wire logic         special_mode,
  input  wire logic         emulation_mode,
  input  wire logic         listen_only,
  input  wire logic         cfg_wr,
  input  wire cmc_cfg_sel_t cfg_sel,
  input  wire logic [7:0]   cfg_wdata,
  input  wire logic         flag_wr,
  input  wire logic [7:0]   ctl0_wdata,
  input  wire logic [7:0]   rflg_wdata,
  input  wire logic [7:0]   rier_wdata,
  input  wire logic [2:0]   tflg_wdata,
  input  wire logic [2:0]   tier_wdata,
  input  wire logic [2:0]   tarq_wdata,
  input  wire logic [2:0]   tbsel_wdata,
  input  wire logic         eng_tx_pending,
  input  wire logic         eng_tx_bit,
  input  wire logic         eng_transmitting,
  input  wire logic         bus_rx_pin,
  input  wire logic         rx_frame_valid,
  input  wire cmc_rx_word_t rx_word,
  input  wire logic         rx_out_ready,
  output logic              rx_in_ready,
  output logic              rx_out_valid,
  output cmc_rx_word_t      rx_out_word,
  output logic              bus_transmit_pin,
  output logic              monitor_bit,
  output logic              tx_start_allow,
  output logic              eng_halt,
  output logic              eng_abort,
  output logic              sleep_acknowledge,
  output logic              init_acknowledge,
  output cmc_cfg_t          cfg,
  output logic [7:0]        control_register_0,
  output logic [7:0]        receiver_flag_register,
  output logic [7:0]        receiver_irq_enable_register,
  output logic [2:0]        transmit_flag_register,
  output logic [2:0]        transmit_irq_enable_register,
  output logic [2:0]        transmit_abort_request_register,
  output logic [2:0]        transmit_abort_ack_register,
  output logic [2:0]        transmit_buffer_select_register
);
  // the one-bit pointers below only serve a two-entry buffer
  if (DEPTH != `CMC_BUF_DEPTH) begin : g_depth_check
    $error("cmc_mode_ctrl: DEPTH must be 2");
  end

  // ----------------------------------------
  // mode state
  // ----------------------------------------
  cmc_state_t state;
  cmc_state_t next_state;
  logic       in_init;
  logic       init_entry;
  logic       cfg_open;

  // emulation_mode is deliberately not consulted: it behaves like normal mode
  assign in_init    = (state == CMC_ST_INIT);
  always_comb begin
    next_state = state;
    case (state)
      CMC_ST_RUN: begin
        if (module_enable_bit && init_request) begin
          next_state = CMC_ST_INIT;
        end else if (sleep_request && !eng_transmitting) begin
          next_state = CMC_ST_SLP;
        end
      end
      CMC_ST_SLP: begin
        if (module_enable_bit && init_request) begin
          next_state = CMC_ST_INIT;
        end else if (!sleep_request) begin
          next_state = CMC_ST_RUN;
        end
      end
      default: begin
        if (!(module_enable_bit && init_request)) begin
          next_state = CMC_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= CMC_ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // combinational so abort and recessive drive hit the same cycle as the request
  assign init_entry        = (state != CMC_ST_INIT) && (next_state == CMC_ST_INIT);
  assign eng_abort         = init_entry;
  assign eng_halt          = in_init || init_entry;
  assign sleep_acknowledge = (state == CMC_ST_SLP);
  assign init_acknowledge  = in_init;

  // ----------------------------------------
  // bus pin and loopback
  // ----------------------------------------
  logic drive_ok;
  assign drive_ok       = !listen_only && !eng_halt;
  assign tx_start_allow = !listen_only && !eng_halt && (state == CMC_ST_RUN) && eng_tx_pending;
  // pin low only when both enabled and the engine asks for dominant
  assign bus_transmit_pin = drive_ok ? eng_tx_bit : `CMC_RECESSIVE;
  // in listen-only mode the monitor sees own dominant even though the line stays recessive
  assign monitor_bit = listen_only ? (bus_rx_pin & eng_tx_bit) : bus_rx_pin;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  assign cfg_open = in_init || special_mode;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= '{`CMC_BTR_RST, `CMC_BTR_RST, `CMC_IDAC_RST, `CMC_FILT_RST, `CMC_FILT_RST};
    end else if (cfg_wr && cfg_open) begin
      case (cfg_sel)
        CMC_W_BTR0: cfg.btr0 <= cfg_wdata;
        CMC_W_BTR1: cfg.btr1 <= cfg_wdata;
        CMC_W_IDAC: cfg.idac <= cfg_wdata;
        default: begin
          cfg.code <= cfg_wdata;
          cfg.mask <= cfg_wdata;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control and flag registers
  // ----------------------------------------
  // registers are not writable during init: the reset to defaults wins over flag_wr there
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_register_0              <= `CMC_CTL0_RST;
      receiver_flag_register          <= `CMC_RFLG_RST;
      receiver_irq_enable_register    <= `CMC_RIER_RST;
      transmit_flag_register          <= `CMC_TFLG_RST;
      transmit_irq_enable_register    <= `CMC_TIER_RST;
      transmit_abort_request_register <= `CMC_TARQ_RST;
      transmit_abort_ack_register     <= `CMC_TAAK_RST;
      transmit_buffer_select_register <= `CMC_TBSEL_RST;
    end else if (eng_halt) begin
      control_register_0              <= `CMC_CTL0_RST;
      receiver_flag_register          <= `CMC_RFLG_RST;
      receiver_irq_enable_register    <= `CMC_RIER_RST;
      transmit_flag_register          <= `CMC_TFLG_RST;
      transmit_irq_enable_register    <= `CMC_TIER_RST;
      transmit_abort_request_register <= `CMC_TARQ_RST;
      transmit_abort_ack_register     <= `CMC_TAAK_RST;
      transmit_buffer_select_register <= `CMC_TBSEL_RST;
    end else if (flag_wr) begin
      control_register_0              <= ctl0_wdata;
      receiver_flag_register          <= rflg_wdata;
      receiver_irq_enable_register    <= rier_wdata;
      transmit_flag_register          <= tflg_wdata;
      transmit_irq_enable_register    <= tier_wdata;
      transmit_abort_request_register <= tarq_wdata;
      transmit_abort_ack_register     <= tarq_wdata & transmit_flag_register;
      transmit_buffer_select_register <= tbsel_wdata;
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  cmc_rx_word_t buf_mem [DEPTH];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  assign rx_in_ready  = (count != 2'h2) && !eng_halt;
  assign rx_out_valid = (count != 2'h0);
  assign push         = rx_frame_valid && rx_in_ready;
  assign pop          = rx_out_valid && rx_out_ready;
  assign rx_out_word  = buf_mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr] <= rx_word;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ### core/cmc_cfg.svh
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH
// ----------------------------------------
// reset values
// ----------------------------------------
`define CMC_CTL0_RST   8'h00
`define CMC_RFLG_RST   8'h00
`define CMC_RIER_RST   8'h00
`define CMC_TFLG_RST   3'h7
`define CMC_TIER_RST   3'h0
`define CMC_TARQ_RST   3'h0
`define CMC_TAAK_RST   3'h0
`define CMC_TBSEL_RST  3'h0
`define CMC_BTR_RST    8'h00
`define CMC_IDAC_RST   8'h00
`define CMC_FILT_RST   8'h00
`define CMC_RECESSIVE  1'b1
`define CMC_DOMINANT   1'b0
`define CMC_BUF_DEPTH  2
`endif

// ### core/cmc_pkg.sv
`default_nettype none
package cmc_pkg;
  typedef enum logic [1:0] {
    CMC_ST_INIT = 2'h0,
    CMC_ST_RUN  = 2'h1,
    CMC_ST_SLP  = 2'h3
  } cmc_state_t;
  typedef enum logic [1:0] {
    CMC_W_BTR0 = 2'h0,
    CMC_W_BTR1 = 2'h1,
    CMC_W_IDAC = 2'h2,
    CMC_W_FILT = 2'h3
  } cmc_cfg_sel_t;
  typedef struct packed {
    logic [7:0] btr0;
    logic [7:0] btr1;
    logic [7:0] idac;
    logic [7:0] code;
    logic [7:0] mask;
  } cmc_cfg_t;
  typedef struct packed {
    logic       is_remote;
    logic [7:0] data;
  } cmc_rx_word_t;
endpackage
`default_nettype wire

// ### verif/cmc_mode_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_mode_ctrl_props (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       module_enable_bit,
  input wire logic       init_request,
  input wire logic       listen_only,
  input wire logic       eng_tx_bit,
  input wire logic       bus_transmit_pin,
  input wire logic       monitor_bit,
  input wire logic       tx_start_allow,
  input wire logic       eng_halt,
  input wire logic       eng_abort,
  input wire logic       init_acknowledge,
  input wire logic [2:0] transmit_flag_register
);
  // ----------------------------------------
  // mode checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_LO_PIN: assert property (listen_only |-> bus_transmit_pin) else $error("dominant out");
  AST_LO_TX: assert property (listen_only |-> !tx_start_allow) else $error("tx start");
  AST_LO_LOOP: assert property (listen_only && !eng_tx_bit |-> !monitor_bit) else $error("no loopback");
  AST_ENTRY: assert property (
    module_enable_bit && init_request && !init_acknowledge |-> bus_transmit_pin) else $error("entry pin");
  AST_INIT: assert property (module_enable_bit && init_request |=> init_acknowledge) else $error("no init");
  AST_ABORT: assert property (eng_abort |=> init_acknowledge) else $error("stray abort");
  AST_HALT: assert property (init_acknowledge |-> eng_halt && bus_transmit_pin) else $error("not halted");
  AST_TFLG: assert property (
    init_acknowledge ##1 init_acknowledge |-> transmit_flag_register == 3'h7) else $error("tflg");
  cover property (eng_abort);
  cover property (listen_only && !eng_tx_bit);
  cover property (init_acknowledge ##1 !init_acknowledge);
endmodule
bind cmc_mode_ctrl cmc_mode_ctrl_props u_props (.clk, .rstn, .module_enable_bit, .init_request, .listen_only,
  .eng_tx_bit, .bus_transmit_pin, .monitor_bit, .tx_start_allow, .eng_halt, .eng_abort, .init_acknowledge,
  .transmit_flag_register);
`default_nettype wire

// ### verif/cmc_bus_node.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// other node on the shared bus
// ----------------------------------------
module cmc_bus_node (
  input  wire logic clk,
  input  wire logic send,
  input  wire logic dut_tx,
  output logic      bus_rx
);
  logic node_tx = 1'h1;
  // toggles while sending so a stuck monitor shows
  always @(posedge clk) node_tx <= send ? ~node_tx : 1'h1;
  // wired-and: dominant wins, idle bus is recessive
  assign bus_rx = node_tx & dut_tx;
endmodule
`default_nettype wire

// ### verif/tb_cmc_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cmc_mode_ctrl;
  import cmc_pkg::*;
  logic         clk = 0, rstn = 0, en = 1, irq = 1, slp = 0, spc = 0, emu = 0, lo = 0, cwr = 0, fwr = 0;
  logic         pend = 0, txb = 1, xmit = 0, rxv = 0, ordy = 0, send = 0;
  logic [7:0]   wd = 8'h00;
  cmc_cfg_sel_t sel = CMC_W_BTR0;
  cmc_rx_word_t rxw = '0, ow;
  cmc_cfg_t     cfg;
  logic         rxp, irdy, ovld, pin, mon, txok, halt, abrt, sak, iak;
  logic [2:0]   tf, ti, ta, tk, tbs;
  logic [7:0]   c0, rf, ri;
  int           n_mismatch = 0, checks = 0;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  always #12.5 clk = ~clk;
  cmc_bus_node u_node (.clk(clk), .send(send), .dut_tx(pin), .bus_rx(rxp));
  cmc_mode_ctrl u_dut (.clk(clk), .rstn(rstn), .module_enable_bit(en), .init_request(irq), .sleep_request(slp),
    .special_mode(spc), .emulation_mode(emu), .listen_only(lo), .cfg_wr(cwr), .cfg_sel(sel), .cfg_wdata(wd),
    .flag_wr(fwr), .ctl0_wdata(wd), .rflg_wdata(wd), .rier_wdata(wd), .tflg_wdata(wd[2:0]),
    .tier_wdata(wd[2:0]), .tarq_wdata(wd[2:0]), .tbsel_wdata(wd[2:0]), .eng_tx_pending(pend),
    .eng_tx_bit(txb), .eng_transmitting(xmit), .bus_rx_pin(rxp), .rx_frame_valid(rxv), .rx_word(rxw),
    .rx_out_ready(ordy), .rx_in_ready(irdy), .rx_out_valid(ovld), .rx_out_word(ow), .bus_transmit_pin(pin),
    .monitor_bit(mon), .tx_start_allow(txok), .eng_halt(halt), .eng_abort(abrt), .sleep_acknowledge(sak),
    .init_acknowledge(iak), .cfg(cfg), .control_register_0(c0), .receiver_flag_register(rf),
    .receiver_irq_enable_register(ri), .transmit_flag_register(tf), .transmit_irq_enable_register(ti),
    .transmit_abort_request_register(ta), .transmit_abort_ack_register(tk),
    .transmit_buffer_select_register(tbs));
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenario
  // ----------------------------------------
  task automatic scen;
    rstn = 0; irq = 1; sel = CMC_W_BTR0;
    repeat (3) cyc;
    chk({iak, halt, pin, tf}, {3'h7, 3'h7});
    rstn = 1; irq = 0;
    cyc;
    chk(iak, 1'b0);
    cwr = 1; wd = 8'h5A;
    cyc;
    chk(cfg.btr0, 8'h00);
    spc = 1;
    cyc;
    cwr = 0; spc = 0; wd = 8'hA6; fwr = 1;
    chk(cfg.btr0, 8'h5A);
    cyc;
    fwr = 0; pend = 1; txb = 0;
    chk({c0, rf, ri}, {3{8'hA6}});
    chk({tf, ti, ta, tk, tbs}, {5{3'h6}});
    cyc;
    chk({pin, txok, mon}, 3'h2);
    lo = 1;
    cyc;
    chk({pin, txok, mon}, 3'h4);
    txb = 1; send = 1; rxv = 1; rxw = {1'h1, 8'hA5};
    cyc;
    rxw = {1'h0, 8'h3C};
    chk(mon, 1'b0);
    cyc;
    rxv = 0;
    chk(mon, 1'b1);
    chk({irdy, ovld, ow}, {1'b0, 1'b1, 1'b1, 8'hA5});
    ordy = 1;
    cyc;
    chk(ow, {1'h0, 8'h3C});
    cyc;
    chk({ovld, pin}, 2'h1);
    ordy = 0; lo = 0; pend = 0; send = 0; xmit = 1; irq = 1;
    #1;
    chk({abrt, pin}, 2'h3);
    cyc;
    xmit = 0;
    cyc;
    chk({iak, halt, irdy, tf}, {3'h6, 3'h7});
    sel = CMC_W_BTR1; wd = 8'h1D; cwr = 1; fwr = 1;
    cyc;
    sel = CMC_W_IDAC; wd = 8'h2E;
    cyc;
    sel = CMC_W_FILT; wd = 8'hC3;
    cyc;
    cwr = 0; fwr = 0;
    chk({cfg.btr1, cfg.idac}, {8'h1D, 8'h2E});
    chk(cfg.code, 8'hC3);
    chk(cfg.mask, 8'hC3);
    chk(tf, 3'h7);
    chk({c0, rf, ri}, {3{8'h00}});
    chk({ti, ta, tk, tbs}, {4{3'h0}});
    irq = 0;
    cyc;
    slp = 1; xmit = 1;
    cyc;
    chk(sak, 1'b0);
    xmit = 0;
    repeat (20) if (sak !== 1'b1) cyc;
    chk(sak, 1'b1);
    irq = 1;
    cyc;
    chk(iak, 1'b1);
    slp = 0;
  endtask
  initial begin
    for (int e = 0; e < 2; e++) begin
      emu = e[0];
      scen;
    end
    end_of_test;
  end
  // whole run is about 44 cycles
  initial begin
    #20000;
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
